//--- inc/sbl_pkg.sv
// Constants, encodings and register map of the serial bootstrap loader
// Summary of operation
// - Boot strap at reset selects loader when high, user when low
// - Discard received bytes until sync byte FF
// - Sync byte sets the rate divider
// - Store bytes at 0x40 through 0xFF, 192 max
// - Silence timeout ends loading early
// - On finish, start executing at 0x40
// - Internal register and RAM hits beat external
// - Register block at 0x00 after reset
// - Internal RAM at 0x40 through 0xFF after reset
// - RAM and registers relocatable on 4K boundaries
// - External RAM at 0x100 through 0x7FFF when fitted and both mode values written
package sbl_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int SILENCE_US = 10000;
  localparam int SILENCE_CYC = SILENCE_US * 1000 / CLK_PERIOD_NS;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [15:0] RX_MIN_LOW = 16'h0002;
  // ----------------------------------------
  // Loader values and memory map
  // ----------------------------------------
  localparam logic [7:0] SYNC_BYTE = 8'hFF;
  localparam int RAM_DEPTH = 192;
  localparam logic [7:0] RAM_LAST_IDX = 8'hBF;
  localparam logic [7:0] RAM_BASE_LO = 8'h40;
  localparam logic [15:0] RUN_PC_RAM = 16'h0040;
  localparam logic [15:0] USER_VECTOR = 16'hFFFE;
  localparam logic [15:0] EXT_LO = 16'h0100;
  localparam logic [15:0] EXT_HI = 16'h7FFF;
  localparam logic [7:0] EXT_MODE_VAL = 8'hE5;
  localparam logic [7:0] EXT_CFG_VAL = 8'h04;
  // ----------------------------------------
  // Register offsets and reset values
  // ----------------------------------------
  localparam logic [5:0] OFS_DIV_LO = 6'h2B;
  localparam logic [5:0] OFS_DIV_HI = 6'h2C;
  localparam logic [5:0] OFS_STATUS = 6'h30;
  localparam logic [5:0] OFS_COUNT = 6'h31;
  localparam logic [5:0] OFS_BMP = 6'h3C;
  localparam logic [5:0] OFS_RELOC = 6'h3D;
  localparam logic [5:0] OFS_SOW = 6'h3F;
  localparam logic [7:0] BMP_RST = 8'h00;
  localparam logic [7:0] SOW_RST = 8'h00;
  localparam logic [7:0] RELOC_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0823;
  // Status bit positions
  localparam int ST_SYNC_BIT = 0;
  localparam int ST_FULL_BIT = 1;
  localparam int ST_TMO_BIT = 2;
  localparam int ST_BOOT_BIT = 3;
  // ----------------------------------------
  // State encodings
  // ----------------------------------------
  typedef enum logic [2:0] {
    LD_STRAP = 3'b000,
    LD_SYNC = 3'b001,
    LD_LOAD = 3'b011,
    LD_RUNRAM = 3'b010,
    LD_USER = 3'b110
  } sbl_ld_st_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } sbl_rx_st_t;
  // CPU read source
  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_REG = 2'b01,
    SRC_RAM = 2'b11
  } sbl_src_t;
endpackage : sbl_pkg

//--- src/sbl_ram.sv
// Internal RAM of 192 bytes with registered read data
`timescale 1ns/1ps
module sbl_ram (
  input wire logic clock,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:sbl_pkg::RAM_DEPTH-1];

  // Read first port, read out of a register
  always_ff @(posedge clock) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : sbl_ram

//--- src/sbl_rx.sv
// Serial receiver with start bit rate measurement
`timescale 1ns/1ps
module sbl_rx (
  input wire logic clock,
  input wire logic rst,
  input wire logic rxd,
  input wire logic measure,
  input wire logic [15:0] div,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic [15:0] rx_meas
);
  typedef struct packed {
    sbl_pkg::sbl_rx_st_t st;
    logic [15:0] cnt;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic [15:0] dv;
    logic prev;
    logic valid;
  } sbl_rx_s_t;
  sbl_rx_s_t s_r;
  sbl_rx_s_t s_nxt;

  // Frame decoder
  always_comb begin
    s_nxt = s_r;
    s_nxt.valid = 1'b0;
    s_nxt.prev = rxd;
    s_nxt.cnt = s_r.cnt + 16'h0001;
    unique case (s_r.st)
      sbl_pkg::RX_IDLE: begin
        s_nxt.cnt = 16'h0000;
        if (s_r.prev && !rxd) begin
          s_nxt.st = sbl_pkg::RX_START;
          s_nxt.dv = measure ? 16'h0000 : div;
        end
      end
      sbl_pkg::RX_START: begin
        if (measure) begin
          // Start bit length of the sync byte is one bit time
          if (rxd) begin
            if (s_r.cnt < sbl_pkg::RX_MIN_LOW) begin
              s_nxt.st = sbl_pkg::RX_IDLE;
            end else begin
              s_nxt.dv = s_r.cnt + 16'h0001;
              s_nxt.cnt = {1'b0, s_r.cnt[15:1]};
              s_nxt.bitn = 3'h0;
              s_nxt.st = sbl_pkg::RX_DATA;
            end
          end
        end else if (s_r.cnt >= {1'b0, s_r.dv[15:1]}) begin
          s_nxt.cnt = 16'h0000;
          s_nxt.bitn = 3'h0;
          s_nxt.st = rxd ? sbl_pkg::RX_IDLE : sbl_pkg::RX_DATA;
        end
      end
      sbl_pkg::RX_DATA: begin
        if (s_r.cnt >= s_r.dv - 16'h0001) begin
          s_nxt.cnt = 16'h0000;
          s_nxt.sh = {rxd, s_r.sh[7:1]};
          s_nxt.bitn = s_r.bitn + 3'h1;
          if (s_r.bitn == 3'h7) begin
            s_nxt.st = sbl_pkg::RX_STOP;
          end
        end
      end
      sbl_pkg::RX_STOP: begin
        if (s_r.cnt >= s_r.dv - 16'h0001) begin
          s_nxt.st = sbl_pkg::RX_IDLE;
          s_nxt.valid = rxd;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.prev <= 1'b1; // Idle line level, so no false start edge
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rx_valid = s_r.valid;
  assign rx_byte = s_r.sh;
  assign rx_meas = s_r.dv;
endmodule : sbl_rx

//--- src/sbl_loader.sv
// Bootstrap loader, register block and internal address decode
`timescale 1ns/1ps
module sbl_loader #(
  parameter int SILENCE_CYCLES = sbl_pkg::SILENCE_CYC,
  parameter bit EXT_RAM_FITTED = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic boot_sel_pin,
  input wire logic rxd_pin,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [7:0] cpu_rdata,
  output logic cpu_ext_sel,
  output logic cpu_int_hit,
  output logic [15:0] run_pc,
  output logic run_go,
  output logic loader_busy
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    sbl_pkg::sbl_ld_st_t st;
    logic bsync1;
    logic bsync2;
    logic rsync1;
    logic rsync2;
    logic [1:0] strap_cnt;
    logic boot;
    logic [7:0] bmp;
    logic [7:0] sow;
    logic [7:0] reloc;
    logic [15:0] div;
    logic sync_seen;
    logic full;
    logic tmo_flag;
    logic [7:0] count;
    logic [7:0] ptr;
    logic [23:0] tmo;
    logic ram_we;
    logic [7:0] ram_idx;
    logic [7:0] ram_wd;
    logic [7:0] rdat;
    sbl_pkg::sbl_src_t csrc;
    logic [7:0] creg_d;
    logic [7:0] crdat;
    logic ext_sel;
    logic int_hit;
    logic [15:0] run_pc;
    logic run_go;
    logic busy;
  } sbl_top_t;
  sbl_top_t s_r;
  sbl_top_t s_nxt;

  logic rx_valid;
  logic [7:0] rx_byte;
  logic [15:0] rx_meas;
  logic [7:0] ram_rdata;
  logic cpu_ok;
  logic hit_reg;
  logic hit_ram;
  logic ext_on;
  logic hit_ext;
  logic acc;
  logic wen;
  logic [5:0] wofs;
  logic [7:0] wdat;

  // Register read mux
  function automatic logic [7:0] rd_val(input logic [5:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      sbl_pkg::OFS_DIV_LO: v = s_r.div[7:0];
      sbl_pkg::OFS_DIV_HI: v = s_r.div[15:8];
      sbl_pkg::OFS_STATUS: begin
        v[sbl_pkg::ST_SYNC_BIT] = s_r.sync_seen;
        v[sbl_pkg::ST_FULL_BIT] = s_r.full;
        v[sbl_pkg::ST_TMO_BIT] = s_r.tmo_flag;
        v[sbl_pkg::ST_BOOT_BIT] = s_r.boot;
        v[6:4] = s_r.st;
      end
      sbl_pkg::OFS_COUNT: v = s_r.count;
      sbl_pkg::OFS_BMP: v = s_r.bmp;
      sbl_pkg::OFS_RELOC: v = s_r.reloc;
      sbl_pkg::OFS_SOW: v = s_r.sow;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : rd_val

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // CPU only runs once loading is over
  assign cpu_ok = (s_r.st == sbl_pkg::LD_USER) || (s_r.st == sbl_pkg::LD_RUNRAM);
  assign acc = cpu_ok && (cpu_rd || cpu_wr);
  // Register block on its 4K page, first 64 bytes
  assign hit_reg = (cpu_addr[15:12] == s_r.reloc[3:0]) && (cpu_addr[11:6] == 6'h00);
  // RAM on its 4K page, 0x40 to 0xFF, below registers in priority
  assign hit_ram = (cpu_addr[15:12] == s_r.reloc[7:4]) && (cpu_addr[11:8] == 4'h0)
    && (cpu_addr[7:6] != 2'b00) && !hit_reg;
  // External access needs both mode values written
  assign ext_on = EXT_RAM_FITTED && (s_r.bmp == sbl_pkg::EXT_MODE_VAL)
    && (s_r.sow == sbl_pkg::EXT_CFG_VAL);
  assign hit_ext = ext_on && (cpu_addr >= sbl_pkg::EXT_LO) && (cpu_addr <= sbl_pkg::EXT_HI)
    && !hit_reg && !hit_ram;
  // Register bus write beats a CPU write in the same cycle
  assign wen = reg_wr || (acc && cpu_wr && hit_reg);
  assign wofs = reg_wr ? reg_addr : cpu_addr[5:0];
  assign wdat = reg_wr ? reg_wdata : cpu_wdata;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.bsync1 = boot_sel_pin;
    s_nxt.bsync2 = s_r.bsync1;
    s_nxt.rsync1 = rxd_pin;
    s_nxt.rsync2 = s_r.rsync1;
    s_nxt.run_go = 1'b0;
    s_nxt.ram_we = 1'b0;
    s_nxt.ram_idx = 8'(cpu_addr[7:0] - sbl_pkg::RAM_BASE_LO);
    s_nxt.ram_wd = cpu_wdata;
    s_nxt.rdat = reg_rd ? rd_val(reg_addr) : 8'h00;
    // Software register writes
    if (wen) begin
      unique case (wofs)
        sbl_pkg::OFS_DIV_LO: s_nxt.div[7:0] = wdat;
        sbl_pkg::OFS_DIV_HI: s_nxt.div[15:8] = wdat;
        sbl_pkg::OFS_BMP: s_nxt.bmp = wdat;
        sbl_pkg::OFS_RELOC: s_nxt.reloc = wdat;
        sbl_pkg::OFS_SOW: s_nxt.sow = wdat;
        default: s_nxt.reloc = s_r.reloc;
      endcase
    end
    // CPU access, decoded in the cycle of the request
    s_nxt.csrc = sbl_pkg::SRC_NONE;
    s_nxt.creg_d = rd_val(cpu_addr[5:0]);
    s_nxt.int_hit = acc && (hit_reg || hit_ram);
    s_nxt.ext_sel = acc && hit_ext;
    if (acc && cpu_rd && hit_reg) begin
      s_nxt.csrc = sbl_pkg::SRC_REG;
    end else if (acc && cpu_rd && hit_ram) begin
      s_nxt.csrc = sbl_pkg::SRC_RAM;
    end
    if (acc && cpu_wr && hit_ram) begin
      s_nxt.ram_we = 1'b1;
    end
    // Second stage of a CPU read
    unique case (s_r.csrc)
      sbl_pkg::SRC_REG: s_nxt.crdat = s_r.creg_d;
      sbl_pkg::SRC_RAM: s_nxt.crdat = ram_rdata;
      default: s_nxt.crdat = 8'h00;
    endcase
    // Loader sequence
    unique case (s_r.st)
      sbl_pkg::LD_STRAP: begin
        s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
        if (s_r.strap_cnt == sbl_pkg::STRAP_WAIT) begin
          s_nxt.boot = s_r.bsync2;
          if (s_r.bsync2) begin
            s_nxt.st = sbl_pkg::LD_SYNC;
          end else begin
            s_nxt.st = sbl_pkg::LD_USER;
            s_nxt.run_pc = sbl_pkg::USER_VECTOR;
            s_nxt.run_go = 1'b1;
          end
        end
      end
      sbl_pkg::LD_SYNC: begin
        // Anything but the sync byte is thrown away
        if (rx_valid && (rx_byte == sbl_pkg::SYNC_BYTE)) begin
          s_nxt.div = rx_meas;
          s_nxt.sync_seen = 1'b1;
          s_nxt.ptr = 8'h00;
          s_nxt.tmo = 24'h000000;
          s_nxt.st = sbl_pkg::LD_LOAD;
        end
      end
      sbl_pkg::LD_LOAD: begin
        s_nxt.tmo = s_r.tmo + 24'h000001;
        if (rx_valid) begin
          s_nxt.tmo = 24'h000000;
          s_nxt.ram_we = 1'b1;
          s_nxt.ram_idx = s_r.ptr;
          s_nxt.ram_wd = rx_byte;
          s_nxt.ptr = s_r.ptr + 8'h01;
          s_nxt.count = s_r.count + 8'h01;
          if (s_r.ptr == sbl_pkg::RAM_LAST_IDX) begin
            s_nxt.full = 1'b1;
            s_nxt.st = sbl_pkg::LD_RUNRAM;
          end
        end else if (s_r.tmo == 24'(SILENCE_CYCLES - 1)) begin
          s_nxt.tmo_flag = 1'b1;
          s_nxt.st = sbl_pkg::LD_RUNRAM;
        end
        if (s_nxt.st == sbl_pkg::LD_RUNRAM) begin
          s_nxt.run_pc = sbl_pkg::RUN_PC_RAM;
          s_nxt.run_go = 1'b1;
        end
      end
      sbl_pkg::LD_RUNRAM: s_nxt.st = sbl_pkg::LD_RUNRAM;
      sbl_pkg::LD_USER: s_nxt.st = sbl_pkg::LD_USER;
      default: s_nxt.st = sbl_pkg::LD_STRAP;
    endcase
    s_nxt.busy = (s_nxt.st != sbl_pkg::LD_USER) && (s_nxt.st != sbl_pkg::LD_RUNRAM);
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.bmp <= sbl_pkg::BMP_RST;
      s_r.sow <= sbl_pkg::SOW_RST;
      s_r.reloc <= sbl_pkg::RELOC_RST;
      s_r.div <= sbl_pkg::DIV_RST;
      s_r.busy <= 1'b1;
      // Receive synchroniser rests at the idle high line level
      s_r.rsync1 <= 1'b1;
      s_r.rsync2 <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Submodules and outputs
  // ----------------------------------------
  sbl_rx u_rx (
    .clock(clock),
    .rst(rst),
    .rxd(s_r.rsync2),
    .measure(s_r.st == sbl_pkg::LD_SYNC),
    .div(s_r.div),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .rx_meas(rx_meas)
  );

  // Fed from the next state so read data line up with the CPU access
  sbl_ram u_ram (
    .clock(clock),
    .we(s_nxt.ram_we),
    .addr(s_nxt.ram_idx),
    .wdata(s_nxt.ram_wd),
    .rdata(ram_rdata)
  );

  assign reg_rdata = s_r.rdat;
  assign cpu_rdata = s_r.crdat;
  assign cpu_ext_sel = s_r.ext_sel;
  assign cpu_int_hit = s_r.int_hit;
  assign run_pc = s_r.run_pc;
  assign run_go = s_r.run_go;
  assign loader_busy = s_r.busy;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_strap_done;
    s_r.st == sbl_pkg::LD_STRAP && s_r.strap_cnt == sbl_pkg::STRAP_WAIT;
  endsequence
  sequence s_sync_ok;
    s_r.st == sbl_pkg::LD_SYNC && rx_valid && rx_byte == sbl_pkg::SYNC_BYTE;
  endsequence
  sequence s_finish;
    s_r.st == sbl_pkg::LD_LOAD ##1 s_r.st == sbl_pkg::LD_RUNRAM;
  endsequence

  property p_strap;
    s_strap_done |=> (s_r.boot ? s_r.st == sbl_pkg::LD_SYNC : (run_go && !loader_busy));
  endproperty
  a_strap: assert property (p_strap) else $error("strap choice wrong");
  property p_discard;
    s_r.st == sbl_pkg::LD_SYNC && rx_valid && rx_byte != sbl_pkg::SYNC_BYTE
      |=> s_r.st == sbl_pkg::LD_SYNC && s_r.count == 8'h00;
  endproperty
  a_discard: assert property (p_discard) else $error("byte before sync kept");
  property p_rate;
    s_sync_ok |=> s_r.st == sbl_pkg::LD_LOAD && s_r.div == $past(rx_meas);
  endproperty
  a_rate: assert property (p_rate) else $error("divider not taken");
  property p_store;
    s_r.st == sbl_pkg::LD_LOAD && rx_valid |=> s_r.ram_we
      && s_r.ram_idx == $past(s_r.ptr) && s_r.ram_wd == $past(rx_byte) ##1 !s_r.ram_we;
  endproperty
  a_store: assert property (p_store) else $error("load byte misplaced");
  property p_full;
    s_r.st == sbl_pkg::LD_LOAD && rx_valid && s_r.ptr == sbl_pkg::RAM_LAST_IDX
      |=> s_r.st == sbl_pkg::LD_RUNRAM && s_r.full && s_r.count == 8'hC0;
  endproperty
  a_full: assert property (p_full) else $error("load did not stop at full");
  property p_tmo;
    s_r.st == sbl_pkg::LD_LOAD && !rx_valid && s_r.tmo == 24'(SILENCE_CYCLES - 1)
      |=> s_r.st == sbl_pkg::LD_RUNRAM && s_r.tmo_flag;
  endproperty
  a_tmo: assert property (p_tmo) else $error("silence did not end load");
  property p_restart;
    s_r.st == sbl_pkg::LD_LOAD && rx_valid |=> s_r.tmo == 24'h000000 ##1 s_r.tmo <= 24'h000001;
  endproperty
  a_restart: assert property (p_restart) else $error("silence count not restarted");
  property p_run;
    s_finish |-> run_pc == sbl_pkg::RUN_PC_RAM && run_go && !loader_busy ##1 !run_go;
  endproperty
  a_run: assert property (p_run) else $error("start from RAM wrong");
  property p_prio;
    acc && hit_reg |=> cpu_int_hit && !cpu_ext_sel;
  endproperty
  a_prio: assert property (p_prio) else $error("external beat internal");
  property p_default_map;
    acc && s_r.reloc == sbl_pkg::RELOC_RST && cpu_addr <= 16'h00FF |=> cpu_int_hit;
  endproperty
  a_default_map: assert property (p_default_map) else $error("low page not internal");
  property p_reloc;
    reg_wr && reg_addr == sbl_pkg::OFS_RELOC |=> s_r.reloc == $past(reg_wdata);
  endproperty
  a_reloc: assert property (p_reloc) else $error("relocation not stored");
  property p_ext;
    acc && !hit_reg && !hit_ram && cpu_addr >= sbl_pkg::EXT_LO && cpu_addr <= sbl_pkg::EXT_HI
      |=> cpu_ext_sel == $past(ext_on) && !cpu_int_hit;
  endproperty
  a_ext: assert property (p_ext) else $error("external select wrong");
endmodule : sbl_loader

//--- dv/sbl_host_tx.sv
// Host serial sender model that drives the loader's receive line
`timescale 1ns/1ps
module sbl_host_tx #(
  parameter int BIT_CYC = 16
) (
  input wire logic clock,
  output logic rxd
);
  // ------------------------------------------------
  // Idle level and frame sender
  // ------------------------------------------------
  // Line rests high between frames
  initial begin
    rxd = 1'b1;
  end

  // One 8N1 frame, LSB first; bit edges just after the clock
  task automatic send_byte(input logic [7:0] b);
    rxd <= 1'b0;
    repeat (BIT_CYC) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      rxd <= b[i];
      repeat (BIT_CYC) @(posedge clock);
    end
    rxd <= 1'b1; // Stop bit, then idle
    repeat (BIT_CYC) @(posedge clock);
  endtask : send_byte
endmodule : sbl_host_tx

//--- dv/sbl_loader_tb.sv
// Self-checking bench for the serial bootstrap loader
`timescale 1ns/1ps
module sbl_loader_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic boot_sel_pin;
  logic rxd_pin;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic [15:0] cpu_addr;
  logic [7:0] cpu_wdata;
  logic cpu_wr;
  logic cpu_rd;
  logic [7:0] cpu_rdata;
  logic cpu_ext_sel, cpu_int_hit, run_go, loader_busy, go_seen, go_busy;
  logic [15:0] run_pc, go_pc;
  logic [7:0] rd;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  // ------------------------------------------------
  // Clock, design, host
  // ------------------------------------------------
  always #25 clock = ~clock;

  sbl_loader #(.SILENCE_CYCLES(200), .EXT_RAM_FITTED(1'b1)) i_sbl_loader (
    .clock(clock), .rst(rst), .boot_sel_pin(boot_sel_pin), .rxd_pin(rxd_pin),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
    .cpu_ext_sel(cpu_ext_sel), .cpu_int_hit(cpu_int_hit), .run_pc(run_pc),
    .run_go(run_go), .loader_busy(loader_busy));

  sbl_host_tx #(.BIT_CYC(16)) i_sbl_host_tx (.clock(clock), .rxd(rxd_pin));

  // Start pulse capture and hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      give_verdict();
    end
    if (run_go === 1'b1) begin
      go_seen <= 1'b1;
      go_pc <= run_pc;
      go_busy <= loader_busy;
    end
  end

  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic do_reset(input logic boot);
    rst <= 1'b1;
    boot_sel_pin <= boot;
    repeat (10) @(posedge clock);
    check({15'h0, loader_busy}, 16'h0001, "busy in reset");
    go_seen = 1'b0;
    rst <= 1'b0;
    // Let the strap settle before the host talks
    repeat (8) @(posedge clock);
  endtask : do_reset

  task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : reg_write

  task automatic reg_read(input logic [5:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
    @(posedge clock);
  endtask : reg_read

  task automatic reg_check(input logic [5:0] a, input logic [7:0] exp);
    reg_read(a, rd);
    check({8'h00, rd}, {8'h00, exp}, "register read");
  endtask : reg_check

  task automatic status_bit(input int b, input logic exp);
    reg_read(sbl_pkg::OFS_STATUS, rd);
    check({15'h0, rd[b]}, {15'h0, exp}, "status bit");
  endtask : status_bit

  task automatic cpu_acc(input logic wr, input logic [15:0] a, input logic [7:0] wd,
                         input logic hit, input logic ext, input logic [7:0] exp);
    cpu_addr <= a;
    cpu_wdata <= wd;
    cpu_wr <= wr;
    cpu_rd <= ~wr;
    @(posedge clock);
    cpu_wr <= 1'b0;
    cpu_rd <= 1'b0;
    @(negedge clock);
    check({15'h0, cpu_int_hit}, {15'h0, hit}, "internal hit");
    check({15'h0, cpu_ext_sel}, {15'h0, ext}, "external select");
    @(posedge clock);
    @(negedge clock);
    if (!wr) check({8'h00, cpu_rdata}, {8'h00, exp}, "cpu read data");
    @(posedge clock);
  endtask : cpu_acc

  task automatic wait_go(input int limit, input logic [15:0] pc);
    for (int n = 0; n < limit && go_seen !== 1'b1; n++) @(posedge clock);
    @(negedge clock);
    check({15'h0, go_seen}, 16'h0001, "start pulse");
    check(go_pc, pc, "start address");
    check({15'h0, go_busy}, 16'h0000, "busy at start");
    @(posedge clock);
  endtask : wait_go

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  // User strap, register reset values, unmapped offset
  task automatic t_user_regs();
    do_reset(1'b0);
    wait_go(20, sbl_pkg::USER_VECTOR);
    reg_check(sbl_pkg::OFS_DIV_LO, sbl_pkg::DIV_RST[7:0]);
    reg_check(sbl_pkg::OFS_DIV_HI, sbl_pkg::DIV_RST[15:8]);
    reg_check(sbl_pkg::OFS_BMP, sbl_pkg::BMP_RST);
    reg_check(sbl_pkg::OFS_SOW, sbl_pkg::SOW_RST);
    reg_check(sbl_pkg::OFS_RELOC, sbl_pkg::RELOC_RST);
    reg_write(6'h10, 8'hA5);
    reg_check(6'h10, 8'h00);
    status_bit(sbl_pkg::ST_BOOT_BIT, 1'b0);
  endtask : t_user_regs

  // Junk before sync, rate capture, short load ended by silence
  task automatic t_sync_load();
    do_reset(1'b1);
    i_sbl_host_tx.send_byte(8'h55);
    i_sbl_host_tx.send_byte(8'h7F);
    repeat (20) @(posedge clock);
    reg_check(sbl_pkg::OFS_COUNT, 8'h00);
    status_bit(sbl_pkg::ST_SYNC_BIT, 1'b0);
    check({15'h0, go_seen}, 16'h0000, "early start");
    i_sbl_host_tx.send_byte(sbl_pkg::SYNC_BYTE);
    repeat (20) @(posedge clock);
    reg_read(sbl_pkg::OFS_DIV_LO, rd);
    check({15'h0, rd >= 8'h0F && rd <= 8'h11}, 16'h0001, "rate divider");
    reg_check(sbl_pkg::OFS_DIV_HI, 8'h00);
    reg_write(sbl_pkg::OFS_STATUS, 8'h00);
    status_bit(sbl_pkg::ST_SYNC_BIT, 1'b1);
    i_sbl_host_tx.send_byte(8'h11);
    i_sbl_host_tx.send_byte(8'h22);
    i_sbl_host_tx.send_byte(8'h33);
    repeat (20) @(posedge clock);
    reg_check(sbl_pkg::OFS_COUNT, 8'h03);
    wait_go(400, sbl_pkg::RUN_PC_RAM);
    status_bit(sbl_pkg::ST_TMO_BIT, 1'b1);
  endtask : t_sync_load

  // Internal decode, external window, relocation
  task automatic t_decode();
    cpu_acc(1'b0, 16'h0040, 8'h00, 1'b1, 1'b0, 8'h11);
    cpu_acc(1'b0, 16'h0042, 8'h00, 1'b1, 1'b0, 8'h33);
    cpu_acc(1'b1, 16'h0060, 8'hA5, 1'b1, 1'b0, 8'h00);
    cpu_acc(1'b0, 16'h0060, 8'h00, 1'b1, 1'b0, 8'hA5);
    cpu_acc(1'b0, 16'h003C, 8'h00, 1'b1, 1'b0, 8'h00);
    cpu_acc(1'b0, 16'h0100, 8'h00, 1'b0, 1'b0, 8'h00);
    reg_write(sbl_pkg::OFS_BMP, sbl_pkg::EXT_MODE_VAL);
    reg_write(sbl_pkg::OFS_SOW, sbl_pkg::EXT_CFG_VAL);
    cpu_acc(1'b0, 16'h0100, 8'h00, 1'b0, 1'b1, 8'h00);
    cpu_acc(1'b0, 16'h7FFF, 8'h00, 1'b0, 1'b1, 8'h00);
    reg_write(sbl_pkg::OFS_RELOC, 8'h21);
    cpu_acc(1'b0, 16'h2060, 8'h00, 1'b1, 1'b0, 8'hA5);
    cpu_acc(1'b0, 16'h2040, 8'h00, 1'b1, 1'b0, 8'h11);
    cpu_acc(1'b0, 16'h1000, 8'h00, 1'b1, 1'b0, 8'h00);
    cpu_acc(1'b0, 16'h0040, 8'h00, 1'b0, 1'b0, 8'h00);
  endtask : t_decode

  // Full RAM ends the load without waiting for silence
  task automatic t_full_load();
    do_reset(1'b1);
    i_sbl_host_tx.send_byte(sbl_pkg::SYNC_BYTE);
    for (int k = 0; k < sbl_pkg::RAM_DEPTH; k++) begin
      i_sbl_host_tx.send_byte(8'(k) ^ 8'h5A);
    end
    wait_go(100, sbl_pkg::RUN_PC_RAM);
    i_sbl_host_tx.send_byte(8'h00);
    repeat (20) @(posedge clock);
    reg_check(sbl_pkg::OFS_COUNT, 8'hC0);
    status_bit(sbl_pkg::ST_FULL_BIT, 1'b1);
    status_bit(sbl_pkg::ST_BOOT_BIT, 1'b1);
    cpu_acc(1'b0, 16'h0040, 8'h00, 1'b1, 1'b0, 8'h5A);
    cpu_acc(1'b0, 16'h00FF, 8'h00, 1'b1, 1'b0, 8'hE5);
  endtask : t_full_load

  // ------------------------------------------------
  // Verdict and main sequence
  // ------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    // Both buses idle before the first reset
    reg_addr <= 6'h00;
    reg_wdata <= 8'h00;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    cpu_addr <= 16'h0000;
    cpu_wdata <= 8'h00;
    cpu_wr <= 1'b0;
    cpu_rd <= 1'b0;
    t_user_regs();
    t_sync_load();
    t_decode();
    t_full_load();
    give_verdict();
  end
endmodule : sbl_loader_tb
